// [irq_prio_pkg.sv]
// Overview of operation
// [R1] sleep timer flag: first register bit 7
// [R2] software keeps first register bit 6 zero
// [R3] port 0 change flag: first register bit 5
// [R4] timer flags bits 4..1, cleared on vector
// [R5] dma done flag: bit 0, read/write
// [R6] second register 7:5 zero, watchdog bit 4
// [R7] port 1 change flag: second register bit 3
// [R8] serial1 or audio tx share bit 2
// [R9] serial0 tx flag: second register bit 1
// [R10] port 2 or usb share bit 0
// [R11] six groups, four levels, two bits
// [R12] all groups lowest level after reset
// [R13] only strictly higher level may nest
// [R14] equal level ties go by polling order
// [R15] high bits register: groups in 5:0
// [R16] level is high bit then low bit
// [R17] fixed mapping of sources onto groups
// [R18] polling order by interrupt number, earliest wins; the code polls in source index order instead (dma first, wdt last)
// [R19] software one acts as request; zero clears
package irq_prio_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int NSRC   = 12;
   localparam int IDX_W  = 4;

   localparam logic [ADDR_W-1:0] OFS_FLAGS_A  = 12'h0C0;
   localparam logic [ADDR_W-1:0] OFS_FLAGS_B  = 12'h0E8;
   localparam logic [ADDR_W-1:0] OFS_PRIO_LO  = 12'h100;
   localparam logic [ADDR_W-1:0] OFS_PRIO_HI  = 12'h104;
   localparam logic [ADDR_W-1:0] OFS_EVT_STAT = 12'h108;
   localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 12'h10C;

   localparam logic [7:0]      FLAGS_A_RST = 8'h00;
   localparam logic [4:0]      FLAGS_B_RST = 5'h00;
   localparam logic [5:0]      PRIO_RST    = 6'h00;
   localparam logic [NSRC-1:0] EVT_RST     = 12'h000;

   // first flag register
   localparam int BIT_ST  = 7;
   localparam int BIT_P0  = 5;
   localparam int BIT_DMA = 0;
   // second flag register
   localparam int BIT_WDT   = 4;
   localparam int BIT_P1    = 3;
   localparam int BIT_TX1   = 2;
   localparam int BIT_TX0   = 1;
   localparam int BIT_P2USB = 0;

   // sources in polling order; timer source k sits at flag bit k
   localparam logic [2:0] SRC_GROUP [NSRC] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5,
                                               3'h5, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
   localparam logic [4:0] SRC_NUM [NSRC] = '{5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h05,
                                             5'h0D, 5'h06, 5'h07, 5'h0E, 5'h0F, 5'h11};
   localparam logic [NSRC-1:0] SRC_AUTOCLR = 12'h01E;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef logic [1:0] level_t;
endpackage

// [irq_level_pick.sv]
`timescale 1ns/1ps
`default_nettype none
module irq_level_pick #(
   parameter int N  = 12,
   parameter int IW = 4
) (
   input  wire logic [N-1:0]   pend,
   input  wire logic [2*N-1:0] lvl,
   output logic                found,
   output logic [IW-1:0]       idx,
   output logic [1:0]          level
);
   always_comb
   begin
      found = 1'b0;
      idx   = '0;
      level = 2'h0;
      // strict compare: an equal level never displaces an earlier source
      for (int i = 0; i < N; i++)
      begin
         if (pend[i] && (!found || lvl[2*i +: 2] > level)) // [R14] [R18]
         begin
            found = 1'b1;
            idx   = IW'(i);
            level = lvl[2*i +: 2];
         end
      end
   end
endmodule
`default_nettype wire

// [irq_flags_and_priority.sv]
`timescale 1ns/1ps
`default_nettype none
module irq_flags_and_priority (
   input  wire logic                           aclk,
   input  wire logic                           aresetn,
   input  wire logic [irq_prio_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                           s_axi_awvalid,
   output logic                                s_axi_awready,
   input  wire logic [irq_prio_pkg::DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]                     s_axi_wstrb,
   input  wire logic                           s_axi_wvalid,
   output logic                                s_axi_wready,
   output logic [1:0]                          s_axi_bresp,
   output logic                                s_axi_bvalid,
   input  wire logic                           s_axi_bready,
   input  wire logic [irq_prio_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                           s_axi_arvalid,
   output logic                                s_axi_arready,
   output logic [irq_prio_pkg::DATA_W-1:0]     s_axi_rdata,
   output logic [1:0]                          s_axi_rresp,
   output logic                                s_axi_rvalid,
   input  wire logic                           s_axi_rready,
   input  wire logic                           st_req,
   input  wire logic                           p0_req,
   input  wire logic                           t1_req,
   input  wire logic                           t2_req,
   input  wire logic                           t3_req,
   input  wire logic                           t4_req,
   input  wire logic                           dma_req,
   input  wire logic                           wdt_req,
   input  wire logic                           p1_req,
   input  wire logic                           serial1_tx_req,
   input  wire logic                           audio_tx_req,
   input  wire logic                           serial0_tx_req,
   input  wire logic                           p2_req,
   input  wire logic                           usb_req,
   output logic                                cpu_irq_req,
   output logic [4:0]                          cpu_irq_num,
   output irq_prio_pkg::level_t                cpu_irq_level,
   input  wire logic                           cpu_vector_ack,
   input  wire logic                           cpu_reti,
   output logic                                irq
);
   import irq_prio_pkg::*;

   // ************************************************************
   // declarations
   // ************************************************************
   logic [ADDR_W-1:0] aw_addr_q;
   logic              aw_hold_q;
   logic [DATA_W-1:0] w_data_q;
   logic [3:0]        w_strb_q;
   logic              w_hold_q;
   logic              do_wr;
   logic              wr_ok;
   logic [NSRC-1:0]   wmask12;
   logic [NSRC-1:0]   wbits12;
   logic              wr_a;
   logic              wr_b;
   logic              wr_lo;
   logic              wr_hi;
   logic              wr_stat;
   logic              wr_mask;
   logic [DATA_W-1:0] rd_word;
   logic              rd_ok;

   logic [7:0]        flags_a_q;
   logic [7:0]        flags_a_d;
   logic [4:0]        flags_b_q;
   logic [4:0]        flags_b_d;
   logic [7:0]        set_a;
   logic [4:0]        set_b;
   logic [7:0]        clr_a;
   logic [5:0]        prio_lo_q;
   logic [5:0]        prio_hi_q;
   logic [NSRC-1:0]   evt_q;
   logic [NSRC-1:0]   mask_q;
   logic [NSRC-1:0]   src_set;
   logic [NSRC-1:0]   src_pend;
   logic [2*NSRC-1:0] src_lvl;

   logic              pick_found;
   logic [IDX_W-1:0]  pick_idx;
   level_t            pick_level;
   logic [IDX_W-1:0]  offer_idx_q;
   logic [3:0]        active_q;
   logic [3:0]        active_d;
   logic [3:0]        top_onehot;
   level_t            top_level;
   logic              nest_ok;
   logic              ack_take;

   // polling-order view of the two flag registers
   function automatic logic [NSRC-1:0] to_src(input logic [7:0] a, input logic [4:0] b);
      to_src = {b[BIT_WDT], b[BIT_P1], b[BIT_TX1], b[BIT_TX0], b[BIT_P2USB],
                a[BIT_P0], a[BIT_ST], a[4:1], a[BIT_DMA]}; // [R17]
   endfunction

   // ************************************************************
   // axi4-lite write channel
   // ************************************************************
   // address and data are caught independently; one write at a time
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_q     <= 1'b0;
         aw_addr_q     <= '0;
         s_axi_awready <= 1'b1;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_hold_q     <= 1'b1;
         aw_addr_q     <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end
      else
      begin
         if (do_wr)
            aw_hold_q <= 1'b0;
         if (s_axi_bvalid && s_axi_bready)
            s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_hold_q     <= 1'b0;
         w_data_q     <= '0;
         w_strb_q     <= 4'h0;
         s_axi_wready <= 1'b1;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_hold_q     <= 1'b1;
         w_data_q     <= s_axi_wdata;
         w_strb_q     <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end
      else
      begin
         if (do_wr)
            w_hold_q <= 1'b0;
         if (s_axi_bvalid && s_axi_bready)
            s_axi_wready <= 1'b1;
      end
   end

   assign do_wr   = aw_hold_q && w_hold_q && !s_axi_bvalid;
   assign wmask12 = {{4{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   assign wbits12 = w_data_q[NSRC-1:0] & wmask12;

   always_comb
   begin
      wr_a    = 1'b0;
      wr_b    = 1'b0;
      wr_lo   = 1'b0;
      wr_hi   = 1'b0;
      wr_stat = 1'b0;
      wr_mask = 1'b0;
      wr_ok   = 1'b1;
      case (aw_addr_q)
         OFS_FLAGS_A:  wr_a    = do_wr && w_strb_q[0];
         OFS_FLAGS_B:  wr_b    = do_wr && w_strb_q[0];
         OFS_PRIO_LO:  wr_lo   = do_wr && w_strb_q[0];
         OFS_PRIO_HI:  wr_hi   = do_wr && w_strb_q[0];
         OFS_EVT_STAT: wr_stat = do_wr;
         OFS_EVT_MASK: wr_mask = do_wr;
         default:      wr_ok   = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else if (do_wr)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // ************************************************************
   // axi4-lite read channel
   // ************************************************************
   always_comb
   begin
      rd_word = '0;
      rd_ok   = 1'b1;
      case (s_axi_araddr)
         OFS_FLAGS_A:  rd_word[7:0]      = flags_a_q;
         OFS_FLAGS_B:  rd_word[4:0]      = flags_b_q; // [R6]
         OFS_PRIO_LO:  rd_word[5:0]      = prio_lo_q;
         OFS_PRIO_HI:  rd_word[5:0]      = prio_hi_q; // [R15]
         OFS_EVT_STAT: rd_word[NSRC-1:0] = evt_q;
         OFS_EVT_MASK: rd_word[NSRC-1:0] = mask_q;
         default:      rd_ok             = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_word;
         s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
      end
   end

   // ************************************************************
   // pending flags
   // ************************************************************
   // bit 6 is plain storage; keeping it zero is up to software
   assign set_a = {st_req, 1'b0, p0_req, t4_req, t3_req, t2_req, t1_req, dma_req}; // [R1] [R3]
   assign set_b = {wdt_req, p1_req, serial1_tx_req | audio_tx_req,
                   serial0_tx_req, p2_req | usb_req}; // [R8] [R10]

   always_comb
   begin
      clr_a = 8'h00;
      if (ack_take && SRC_AUTOCLR[offer_idx_q])
         clr_a[offer_idx_q[2:0]] = 1'b1; // [R4]
   end

   // a request in the cycle of a clear or a zero write is kept
   assign flags_a_d = set_a | (~clr_a & (wr_a ? w_data_q[7:0] : flags_a_q)); // [R4] [R5] [R19]
   assign flags_b_d = set_b | (wr_b ? w_data_q[4:0] : flags_b_q); // [R7] [R9] [R19]

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         flags_a_q <= FLAGS_A_RST;
      else
         flags_a_q <= flags_a_d;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         flags_b_q <= FLAGS_B_RST; // [R6]
      else
         flags_b_q <= flags_b_d;
   end

   // ************************************************************
   // priority registers
   // ************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         prio_lo_q <= PRIO_RST; // [R12]
         prio_hi_q <= PRIO_RST; // [R12]
      end
      else
      begin
         if (wr_lo)
            prio_lo_q <= w_data_q[5:0];
         if (wr_hi)
            prio_hi_q <= w_data_q[5:0]; // [R15]
      end
   end

   // ************************************************************
   // event status, mask and interrupt line
   // ************************************************************
   // only hardware requests are logged, not software writes
   assign src_set = to_src(set_a, set_b);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         evt_q <= EVT_RST;
      else
         evt_q <= src_set | (evt_q & ~(wr_stat ? wbits12 : EVT_RST));
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mask_q <= EVT_RST;
      else if (wr_mask)
         mask_q <= (mask_q & ~wmask12) | wbits12;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq <= 1'b0;
      else
         irq <= |(evt_q & mask_q);
   end

   // ************************************************************
   // arbitration and nesting
   // ************************************************************
   assign src_pend = to_src(flags_a_q, flags_b_q);

   always_comb
   begin
      src_lvl = '0;
      for (int i = 0; i < NSRC; i++)
         src_lvl[2*i +: 2] = {prio_hi_q[SRC_GROUP[i]], prio_lo_q[SRC_GROUP[i]]}; // [R11] [R16]
   end

   irq_level_pick #(
      .N  (NSRC),
      .IW (IDX_W)
   ) u_pick (
      .pend  (src_pend),
      .lvl   (src_lvl),
      .found (pick_found),
      .idx   (pick_idx),
      .level (pick_level)
   );

   always_comb
   begin
      top_level  = 2'h0;
      top_onehot = 4'h0;
      for (int l = 0; l < 4; l++)
      begin
         if (active_q[l])
         begin
            top_level  = level_t'(l);
            top_onehot = 4'h1 << l;
         end
      end
   end

   assign nest_ok  = (active_q == 4'h0) || (pick_level > top_level); // [R13]
   assign ack_take = cpu_vector_ack && cpu_irq_req;

   always_comb
   begin
      active_d = active_q;
      if (cpu_reti)
         active_d = active_d & ~top_onehot;
      if (ack_take)
         active_d[cpu_irq_level] = 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         active_q <= 4'h0;
      else
         active_q <= active_d;
   end

   // request drops for one cycle after an ack so the cpu never takes a stale offer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cpu_irq_req   <= 1'b0;
         cpu_irq_num   <= 5'h00;
         cpu_irq_level <= 2'h0;
         offer_idx_q   <= '0;
      end
      else
      begin
         cpu_irq_req   <= pick_found && nest_ok && !ack_take; // [R13]
         cpu_irq_num   <= SRC_NUM[pick_idx]; // [R18]
         cpu_irq_level <= pick_level;
         offer_idx_q   <= pick_idx;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   level_t offer_lvl;
   assign offer_lvl = {prio_hi_q[SRC_GROUP[offer_idx_q]], prio_lo_q[SRC_GROUP[offer_idx_q]]};

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   chk_st_flag_set: // [R1]
      assert property (st_req |=> flags_a_q[BIT_ST])
      else $error("sleep timer flag not set by request");

   chk_timer_autoclr: // [R4]
      assert property (ack_take && SRC_AUTOCLR[offer_idx_q] && !src_set[offer_idx_q]
                       |=> !src_pend[$past(offer_idx_q)])
      else $error("timer flag not cleared on vector");

   chk_dma_sw_write: // [R5]
      assert property (wr_a && !dma_req |=> flags_a_q[BIT_DMA] == $past(w_data_q[BIT_DMA]))
      else $error("dma flag does not follow software write");

   chk_flags_b_unused: // [R6]
      assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_FLAGS_B
                       |=> s_axi_rvalid && s_axi_rdata[7:5] == 3'h0)
      else $error("unused flag bits read nonzero");

   chk_shared_tx: // [R8]
      assert property (serial1_tx_req || audio_tx_req |=> flags_b_q[BIT_TX1])
      else $error("shared tx flag not set");

   chk_shared_p2usb: // [R10]
      assert property (p2_req || usb_req |=> flags_b_q[BIT_P2USB])
      else $error("shared port2 usb flag not set");

   chk_levels_reset: // [R12]
      assert property ($rose(aresetn) |-> prio_lo_q == PRIO_RST && prio_hi_q == PRIO_RST)
      else $error("priority not lowest after reset");

   chk_no_preempt: // [R13]
      assert property (cpu_irq_req |-> active_q == 4'h0 || cpu_irq_level > top_level)
      else $error("request offered at equal or lower level");

   chk_level_map: // [R16]
      assert property (cpu_irq_req && $stable(prio_hi_q) && $stable(prio_lo_q)
                       |-> cpu_irq_level == offer_lvl)
      else $error("offered level does not match group bits");

   chk_ack_then_quiet: // [R13]
      assert property (ack_take |=> !cpu_irq_req ##1 active_q != 4'h0 || $past(cpu_reti))
      else $error("ack not followed by quiet cycle");

   cov_vector: cover property (ack_take);
   cov_nested: cover property (active_q[3] && active_q[0]);
   cov_irq_line: cover property (!irq ##1 irq);
   cov_tie: cover property (pick_found && src_pend[0] && src_pend[1] && pick_idx == 4'h0);
endmodule
`default_nettype wire

// [cpu_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       cpu_irq_req,
   input  wire logic [4:0] cpu_irq_num,
   input  wire logic [1:0] cpu_irq_level,
   input  wire logic       take,
   input  wire logic       slow,
   input  wire logic       ret_cmd,
   output logic            cpu_vector_ack,
   output logic            cpu_reti,
   output logic            got_stb,
   output logic [4:0]      got_num,
   output logic [1:0]      got_level
);
   logic [1:0] wait_q;

   // a slow core lets the offer stand three cycles longer before vectoring
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cpu_vector_ack <= 1'b0;
         cpu_reti       <= 1'b0;
         got_stb        <= 1'b0;
         got_num        <= 5'h00;
         got_level      <= 2'h0;
         wait_q         <= 2'h0;
      end
      else
      begin
         cpu_reti <= ret_cmd;
         got_stb  <= cpu_vector_ack & cpu_irq_req;
         if (cpu_vector_ack & cpu_irq_req)
         begin
            got_num   <= cpu_irq_num;
            got_level <= cpu_irq_level;
         end
         cpu_vector_ack <= take & cpu_irq_req & ~cpu_vector_ack & (!slow | wait_q == 2'h3);
         wait_q <= (take & cpu_irq_req & ~cpu_vector_ack) ? wait_q + 2'h1 : 2'h0;
      end
   end
endmodule
`default_nettype wire

// [irq_flags_and_priority_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module irq_flags_and_priority_tb;
   import irq_prio_pkg::*;
   // ****
   // signals
   // ****
   logic        aclk, aresetn;
   logic [11:0] s_axi_awaddr, s_axi_araddr, pend;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed, rd_d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, cpu_irq_level, got_level, rd_r;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        cpu_irq_req, cpu_vector_ack, cpu_reti, irq, take, slow, ret_cmd, got_stb;
   logic [4:0]  cpu_irq_num, got_num;
   logic [13:0] rq;
   logic [5:0]  lo_v, hi_v;
   int          n_fail, n_tests, w, v, t, lw;
   localparam int GRP [12] = '{0, 1, 2, 3, 4, 5, 5, 1, 2, 3, 4, 5};
   localparam int NUM [12] = '{8, 9, 10, 11, 12, 5, 13, 6, 7, 14, 15, 17};
   // {second flags, first flags} expected per request line
   localparam logic [15:0] MAP [14] = '{16'h0080, 16'h0020, 16'h0002, 16'h0004, 16'h0008,
      16'h0010, 16'h0001, 16'h1000, 16'h0800, 16'h0400, 16'h0400, 16'h0200, 16'h0100, 16'h0100};

   irq_flags_and_priority dut_u (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .st_req(rq[0]), .p0_req(rq[1]), .t1_req(rq[2]),
      .t2_req(rq[3]), .t3_req(rq[4]), .t4_req(rq[5]), .dma_req(rq[6]), .wdt_req(rq[7]),
      .p1_req(rq[8]), .serial1_tx_req(rq[9]), .audio_tx_req(rq[10]),
      .serial0_tx_req(rq[11]), .p2_req(rq[12]), .usb_req(rq[13]), .cpu_irq_req,
      .cpu_irq_num, .cpu_irq_level, .cpu_vector_ack, .cpu_reti, .irq
   );
   cpu_core_model cpu_u (
      .aclk, .aresetn, .cpu_irq_req, .cpu_irq_num, .cpu_irq_level, .take, .slow, .ret_cmd,
      .cpu_vector_ack, .cpu_reti, .got_stb, .got_num, .got_level
   );

   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   // ****
   // helpers
   // ****
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // bready stays up until bvalid is seen; each bus task starts on a fresh edge
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask

   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
      rd(a);
      chk(nm, e, rd_d);
      chk("rresp", {30'h0, RESP_OKAY}, {30'h0, rd_r});
   endtask

   // core vectors to the standing offer; gives up after 20 cycles when none stands
   task automatic vec();
      take <= 1'b1;
      for (t = 0; t < 20 && !got_stb; t++) @(posedge aclk);
      take <= 1'b0;
   endtask

   task automatic pulse(input logic [13:0] p);
      @(posedge aclk);
      rq <= p;
      @(posedge aclk);
      rq <= 14'h0000;
   endtask

   function automatic int lvl(input int i);
      return {30'h0, hi_v[GRP[i]], lo_v[GRP[i]]};
   endfunction

   // winner among pending sources above a level; earlier in polling order wins a tie
   function automatic int pick(input logic [11:0] p, input int min_l);
      int b;
      b = -1;
      for (int i = 0; i < 12; i++)
         if (p[i] && lvl(i) > min_l && (b < 0 || lvl(i) > lvl(b))) b = i;
      return b;
   endfunction

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      conclude();
   end

   // ****
   // tests
   // ****
   initial
   begin
      n_fail = 0;
      n_tests = 0;
      seed = 32'hABC9;
      aresetn = 1'b0;
      rq = 14'h0000;
      {take, slow, ret_cmd, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h00;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      s_axi_awaddr = 12'h000;
      s_axi_araddr = 12'h000;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(OFS_FLAGS_A, 32'h0, "flags_a reset");
      rdc(OFS_FLAGS_B, 32'h0, "flags_b reset");
      rdc(OFS_PRIO_LO, 32'h0, "prio_lo reset");
      rdc(OFS_PRIO_HI, 32'h0, "prio_hi reset");
      wr(OFS_FLAGS_B, 32'hFF, RESP_OKAY);
      rdc(OFS_FLAGS_B, 32'h1F, "flags_b unused bits");
      wr(OFS_PRIO_HI, 32'hFF, RESP_OKAY);
      rdc(OFS_PRIO_HI, 32'h3F, "prio_hi unused bits");
      // no byte lane enabled: the write is answered but must not land
      s_axi_wstrb <= 4'h0;
      wr(OFS_PRIO_LO, 32'h3F, RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      rdc(OFS_PRIO_LO, 32'h0, "prio_lo without strobe");
      wr(OFS_FLAGS_A, 32'hBF, RESP_OKAY);
      rdc(OFS_FLAGS_A, 32'hBF, "flags_a write");
      wr(12'h200, 32'h1, RESP_SLVERR);
      rd(12'h200);
      chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, rd_r});
      $display("test registers done");
      for (int k = 0; k < 14; k++)
      begin
         wr(OFS_FLAGS_A, 32'h0, RESP_OKAY);
         wr(OFS_FLAGS_B, 32'h0, RESP_OKAY);
         pulse(14'h0001 << k);
         rdc(OFS_FLAGS_A, {24'h0, MAP[k][7:0]}, "request flags_a");
         rdc(OFS_FLAGS_B, {24'h0, MAP[k][15:8]}, "request flags_b");
      end
      $display("test request mapping done");
      wr(OFS_FLAGS_A, 32'h0, RESP_OKAY);
      wr(OFS_FLAGS_B, 32'h0, RESP_OKAY);
      wr(OFS_EVT_STAT, 32'hFFF, RESP_OKAY);
      pulse(14'h0008);
      rdc(OFS_EVT_STAT, 32'h004, "event status");
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(OFS_EVT_MASK, 32'h004, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      wr(OFS_EVT_STAT, 32'h004, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rdc(OFS_EVT_STAT, 32'h0, "event status cleared");
      wr(OFS_FLAGS_A, 32'h0, RESP_OKAY);
      $display("test events done");
      for (int n = 0; n < 10; n++)
      begin
         seed = xs(seed);
         {hi_v, lo_v, pend} = {seed[29:24], seed[21:16], seed[11:0] | 12'h001};
         // first two rounds: every source pending at one shared level
         if (n < 2) {hi_v, lo_v, pend} = {{12{n[0]}}, 12'hFFF};
         wr(OFS_PRIO_LO, {26'h0, lo_v}, RESP_OKAY);
         wr(OFS_PRIO_HI, {26'h0, hi_v}, RESP_OKAY);
         wr(OFS_FLAGS_A, {24'h0, pend[5], 1'b0, pend[6], pend[4:0]}, RESP_OKAY);
         wr(OFS_FLAGS_B, {27'h0, pend[11:7]}, RESP_OKAY);
         w = pick(pend, -1);
         repeat (3) @(posedge aclk);
         chk("offer num", NUM[w], {27'h0, cpu_irq_num});
         chk("offer level", lvl(w), {30'h0, cpu_irq_level});
         slow <= n[0];
         vec();
         chk("taken num", NUM[w], {27'h0, got_num});
         if (w >= 1 && w <= 4) pend[w] = 1'b0;
         rdc(OFS_FLAGS_A, {24'h0, pend[5], 1'b0, pend[6], pend[4:0]}, "vector clear");
         // all groups to the top level: only a strictly higher level may nest
         lw = lvl(w);
         {hi_v, lo_v} = 12'hFFF;
         wr(OFS_PRIO_LO, 32'h3F, RESP_OKAY);
         wr(OFS_PRIO_HI, 32'h3F, RESP_OKAY);
         repeat (2) @(posedge aclk);
         v = pick(pend, lw);
         chk("nested offer", {31'h0, v >= 0}, {31'h0, cpu_irq_req});
         if (v >= 0) chk("nested num", NUM[v], {27'h0, cpu_irq_num});
         vec();
         if (v >= 0) chk("nested taken", NUM[v], {27'h0, got_num});
         ret_cmd <= 1'b1;
         repeat (2) @(posedge aclk);
         ret_cmd <= 1'b0;
         repeat (3) @(posedge aclk);
         chk("offer after return", {31'h0, pick(pend, -1) >= 0}, {31'h0, cpu_irq_req});
         wr(OFS_FLAGS_A, 32'h0, RESP_OKAY);
         wr(OFS_FLAGS_B, 32'h0, RESP_OKAY);
      end
      $display("test arbitration done");
      conclude();
   end
endmodule
`default_nettype wire
